// ===== hdl/tso_timer_ctl.sv
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tso_map.svh"
module tso_timer_ctl import tso_pkg::*; (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire tso_mode_t mode_i,
  input wire logic [7:0] chan_flag_set_i,
  input wire logic [7:0] force_i,
  input wire logic [7:0] force_level_i,
  input wire logic [7:0] oc7_mask_i,
  input wire logic [7:0] oc7_data_i,
  input wire logic ch7_compare_i,
  input wire logic acc_ovf_set_i,
  input wire logic acc_in_set_i,
  input wire logic [15:0] acc_count_i,
  output logic [15:0] counter_o,
  output logic [7:0] oc_pin_o,
  output logic [7:0] oc_enable_o,
  output logic acc_div64_o,
  output logic acc_run_o,
  output logic module_stop_o
);
  // ===================================================================
  // state
  tso_ctl_t ctl_reg;
  logic precision_select_bit_lock_reg;
  logic [7:0] toggle_reg;
  logic [7:0] select_reg;
  logic [7:0] sysctl2_reg;
  logic [7:0] precision_reg;
  logic [7:0] chflg_reg;
  logic ovf_flag_reg;
  logic [1:0] accflg_reg;
  logic [7:0] chan_val_reg [0:15];
  logic [15:0] cnt_reg;
  logic [7:0] psc_cnt_reg;
  logic [5:0] div_cnt_reg;
  logic [7:0] pin_reg;
  logic [31:0] prdata_reg;

  // ===================================================================
  // bus decode
  logic [5:0] idx;
  logic aligned;
  logic setup;
  logic access;
  logic wr;
  logic in_chan;
  logic [2:0] chan;
  logic mapped;
  logic [7:0] wbyte;
  assign idx = paddr_i[7:2];
  assign aligned = (paddr_i[1:0] == 2'b00);
  assign setup = psel_i && !penable_i;
  assign access = psel_i && penable_i;
  assign wr = access && pwrite_i;
  assign wbyte = pwdata_i[7:0];
  assign in_chan = (idx >= `TSO_IDX_CHAN_FIRST) &&
                   (idx <= `TSO_IDX_CHAN_LAST);
  assign chan = idx[3:1];
  always_comb begin
    unique case (idx)
      `TSO_IDX_SELECT, `TSO_IDX_CNT_HI, `TSO_IDX_CNT_LO,
      `TSO_IDX_SYSCTL1, `TSO_IDX_TOGGLE, `TSO_IDX_SYSCTL2,
      `TSO_IDX_CHFLG, `TSO_IDX_OVFLG, `TSO_IDX_ACCFLG,
      `TSO_IDX_ACC_HI, `TSO_IDX_ACC_LO, `TSO_IDX_PRECISION: begin
        mapped = aligned;
      end
      default: begin
        mapped = aligned && in_chan;
      end
    endcase
  end
  assign pready_o = 1'b1;
  assign pslverr_o = access && !mapped;
  assign prdata_o = prdata_reg;

  // ===================================================================
  // run conditions
  logic wait_stop;
  logic timer_active;
  logic cnt_run;
  logic cnt_tick;
  logic [7:0] psc_limit;
  logic ovf_evt;
  logic ch7_evt;
  logic cnt_wr;
  assign wait_stop = mode_i.wait_mode && ctl_reg.stop_in_wait_bit;
  assign module_stop_o = wait_stop;
  assign acc_run_o = !wait_stop;
  assign timer_active = ctl_reg.timer_enable_bit && !wait_stop;
  assign cnt_run = timer_active &&
                   !(mode_i.freeze_mode && ctl_reg.stop_in_freeze_bit);
  // legacy divide is a power of two, precision divide is value plus one
  assign psc_limit = ctl_reg.precision_select_bit ? precision_reg :
    8'((9'h001 << sysctl2_reg[`TSO_LEGACY_MSB:0]) - 9'h001);
  assign cnt_tick = cnt_run && (psc_cnt_reg == psc_limit);
  assign ovf_evt = cnt_tick && (cnt_reg == `TSO_CNT_MAX);
  assign ch7_evt = (ovf_evt && toggle_reg[7]) || ch7_compare_i;
  assign cnt_wr = wr && mode_i.test_mode &&
                  (idx == `TSO_IDX_CNT_HI || idx == `TSO_IDX_CNT_LO);
  assign acc_div64_o = timer_active &&
                       (div_cnt_reg == `TSO_DIV64_LAST);
  assign counter_o = cnt_reg;
  assign oc_pin_o = pin_reg;
  assign oc_enable_o = select_reg;

  // ===================================================================
  // prescaler, divide-by-64 and counter
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      psc_cnt_reg <= `TSO_RST_BYTE;
    end else if (!cnt_run || cnt_tick) begin
      psc_cnt_reg <= `TSO_RST_BYTE;
    end else begin
      psc_cnt_reg <= psc_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      div_cnt_reg <= 6'h00;
    end else if (timer_active) begin
      div_cnt_reg <= div_cnt_reg + 6'h01;
    end
  end

  // writes in test mode only; the first count after one may be short
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_reg <= `TSO_RST_CNT;
    end else if (cnt_wr && idx == `TSO_IDX_CNT_HI) begin
      cnt_reg <= {wbyte, cnt_reg[7:0]};
    end else if (cnt_wr) begin
      cnt_reg <= {cnt_reg[15:8], wbyte};
    end else if (cnt_tick) begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  // ===================================================================
  // control registers
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctl_reg <= `TSO_RST_CTL;
      precision_select_bit_lock_reg <= 1'b0;
    end else if (wr && aligned && idx == `TSO_IDX_SYSCTL1) begin
      ctl_reg.timer_enable_bit <= wbyte[7];
      ctl_reg.stop_in_wait_bit <= wbyte[6];
      ctl_reg.stop_in_freeze_bit <= wbyte[5];
      ctl_reg.fast_flag_clear_bit <= wbyte[4];
      precision_select_bit_lock_reg <= 1'b1;
      if (!precision_select_bit_lock_reg) begin
        ctl_reg.precision_select_bit <= wbyte[3];
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      toggle_reg <= `TSO_RST_BYTE;
      select_reg <= `TSO_RST_BYTE;
      sysctl2_reg <= `TSO_RST_BYTE;
      precision_reg <= `TSO_RST_BYTE;
    end else if (wr && aligned) begin
      if (idx == `TSO_IDX_TOGGLE) begin
        toggle_reg <= wbyte;
      end
      if (idx == `TSO_IDX_SELECT) begin
        select_reg <= wbyte;
      end
      if (idx == `TSO_IDX_SYSCTL2) begin
        sysctl2_reg <= wbyte;
      end
      if (idx == `TSO_IDX_PRECISION) begin
        precision_reg <= wbyte;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (wr && aligned && in_chan) begin
      chan_val_reg[idx[3:0]] <= wbyte;
    end
  end

  // ===================================================================
  // flags: a set in the clearing cycle wins
  logic fast;
  logic [7:0] ch_clr;
  logic ovf_clr;
  logic [1:0] acc_clr;
  logic [1:0] acc_set;
  assign fast = ctl_reg.fast_flag_clear_bit && access && aligned;
  always_comb begin
    ch_clr = (wr && aligned && idx == `TSO_IDX_CHFLG) ? wbyte : 8'h00;
    if (fast && in_chan &&
        (pwrite_i == select_reg[chan])) begin
      ch_clr[chan] = 1'b1;
    end
  end
  assign ovf_clr = (wr && aligned && idx == `TSO_IDX_OVFLG &&
                    wbyte[`TSO_BIT_OVF]) ||
                   (fast && (idx == `TSO_IDX_CNT_HI ||
                             idx == `TSO_IDX_CNT_LO));
  assign acc_clr = ((wr && aligned && idx == `TSO_IDX_ACCFLG) ?
                    wbyte[1:0] : 2'b00) |
                   {2{fast && (idx == `TSO_IDX_ACC_HI ||
                               idx == `TSO_IDX_ACC_LO)}};
  assign acc_set = {acc_ovf_set_i && acc_run_o, acc_in_set_i && acc_run_o};

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      chflg_reg <= `TSO_RST_BYTE;
      ovf_flag_reg <= 1'b0;
      accflg_reg <= 2'b00;
    end else begin
      chflg_reg <= (chflg_reg & ~ch_clr) |
                   (chan_flag_set_i & {8{!wait_stop}});
      ovf_flag_reg <= (ovf_flag_reg && !ovf_clr) || ovf_evt;
      accflg_reg <= (accflg_reg & ~acc_clr) | acc_set;
    end
  end

  // ===================================================================
  // compare pins: override, then overflow toggle, then force
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_reg <= `TSO_RST_BYTE;
    end else begin
      for (int k = 0; k < 8; k++) begin
        if (select_reg[k]) begin
          if (k < 7 && ch7_evt && oc7_mask_i[k]) begin
            pin_reg[k] <= oc7_data_i[k];
          end else if (ovf_evt && toggle_reg[k]) begin
            pin_reg[k] <= !pin_reg[k];
          end else if (force_i[k]) begin
            pin_reg[k] <= force_level_i[k];
          end
        end
      end
    end
  end

  // ===================================================================
  // read data, sampled in the setup cycle
  logic [7:0] rbyte;
  always_comb begin
    rbyte = 8'h00;
    if (in_chan) begin
      rbyte = chan_val_reg[idx[3:0]];
    end
    unique case (idx)
      `TSO_IDX_SELECT: rbyte = select_reg;
      `TSO_IDX_CNT_HI: rbyte = cnt_reg[15:8];
      `TSO_IDX_CNT_LO: rbyte = cnt_reg[7:0];
      `TSO_IDX_SYSCTL1: rbyte = {ctl_reg, 3'b000};
      `TSO_IDX_TOGGLE: rbyte = toggle_reg;
      `TSO_IDX_SYSCTL2: rbyte = sysctl2_reg;
      `TSO_IDX_CHFLG: rbyte = chflg_reg;
      `TSO_IDX_OVFLG: rbyte = {ovf_flag_reg, 7'h00};
      `TSO_IDX_ACCFLG: rbyte = {6'h00, accflg_reg};
      `TSO_IDX_ACC_HI: rbyte = acc_count_i[15:8];
      `TSO_IDX_ACC_LO: rbyte = acc_count_i[7:0];
      `TSO_IDX_PRECISION: rbyte = precision_reg;
      default: ;
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup) begin
      prdata_reg <= (mapped && !pwrite_i) ? {24'h000000, rbyte} : 32'h0;
    end
  end

  // ===================================================================
  // checks
  property p_halt;
    @(posedge clk_i) disable iff (reset_i)
    (!ctl_reg.timer_enable_bit && !cnt_wr) |=> $stable(cnt_reg);
  endproperty
  a_halt: assert property (p_halt) else $error("counter moved while off");

  property p_div64;
    @(posedge clk_i) disable iff (reset_i)
    !timer_active |-> !acc_div64_o;
  endproperty
  a_div64: assert property (p_div64) else $error("div64 while inactive");

  property p_wait;
    @(posedge clk_i) disable iff (reset_i)
    (mode_i.wait_mode && ctl_reg.stop_in_wait_bit && !cnt_wr)
      |-> !acc_run_o && module_stop_o ##1 $stable(cnt_reg);
  endproperty
  a_wait: assert property (p_wait) else $error("module ran in wait");

  property p_run;
    @(posedge clk_i) disable iff (reset_i)
    (cnt_tick && !cnt_wr) |=> cnt_reg == $past(cnt_reg) + 16'h0001;
  endproperty
  a_run: assert property (p_run) else $error("counter did not step");

  property p_freeze;
    @(posedge clk_i) disable iff (reset_i)
    (mode_i.freeze_mode && ctl_reg.stop_in_freeze_bit && !cnt_wr)
      |=> $stable(cnt_reg);
  endproperty
  a_freeze: assert property (p_freeze) else $error("ran in freeze");

  property p_acc_freeze;
    @(posedge clk_i) disable iff (reset_i)
    (mode_i.freeze_mode && !mode_i.wait_mode) |-> acc_run_o;
  endproperty
  a_acc_freeze: assert property (p_acc_freeze) else $error("acc stopped");

  property p_fast_ovf;
    @(posedge clk_i) disable iff (reset_i)
    (fast && idx == `TSO_IDX_CNT_LO && !ovf_evt) |=> !ovf_flag_reg;
  endproperty
  a_fast_ovf: assert property (p_fast_ovf) else $error("ovf not cleared");

  property p_fast_acc;
    @(posedge clk_i) disable iff (reset_i)
    (fast && idx == `TSO_IDX_ACC_HI && !acc_ovf_set_i && !acc_in_set_i)
      |=> accflg_reg == 2'b00;
  endproperty
  a_fast_acc: assert property (p_fast_acc) else $error("acc flags kept");

  property p_once;
    @(posedge clk_i) disable iff (reset_i)
    precision_select_bit_lock_reg |=> $stable(ctl_reg.precision_select_bit);
  endproperty
  a_once: assert property (p_once) else $error("precision rewritten");

  property p_toggle;
    @(posedge clk_i) disable iff (reset_i)
    (ovf_evt && toggle_reg[0] && select_reg[0] &&
     !(ch7_evt && oc7_mask_i[0])) |=> pin_reg[0] != $past(pin_reg[0]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("no toggle");

  property p_capture;
    @(posedge clk_i) disable iff (reset_i)
    !select_reg[1] |=> $stable(pin_reg[1]);
  endproperty
  a_capture: assert property (p_capture) else $error("capture pin moved");

  property p_low_zero;
    @(posedge clk_i) disable iff (reset_i)
    (access && idx == `TSO_IDX_SYSCTL1) |-> prdata_o[2:0] == 3'b000;
  endproperty
  a_low_zero: assert property (p_low_zero) else $error("low bits set");

  c_ovf: cover property (@(posedge clk_i) disable iff (reset_i) ovf_evt);
  c_fast_ch: cover property (@(posedge clk_i) disable iff (reset_i)
    fast && in_chan && chflg_reg[chan]);
  c_override: cover property (@(posedge clk_i) disable iff (reset_i)
    ch7_evt && oc7_mask_i[0] && select_reg[0]);
  c_lock: cover property (@(posedge clk_i) disable iff (reset_i)
    precision_select_bit_lock_reg && wr && idx == `TSO_IDX_SYSCTL1);
endmodule
`default_nettype wire

// ===== inc/tso_map.svh
`ifndef TSO_MAP_SVH
`define TSO_MAP_SVH
// =====================================================================
// register indices (byte address is four times the index)
`define TSO_IDX_SELECT 6'h00
`define TSO_IDX_CNT_HI 6'h04
`define TSO_IDX_CNT_LO 6'h05
`define TSO_IDX_SYSCTL1 6'h06
`define TSO_IDX_TOGGLE 6'h07
`define TSO_IDX_SYSCTL2 6'h0d
`define TSO_IDX_CHFLG 6'h0e
`define TSO_IDX_OVFLG 6'h0f
`define TSO_IDX_CHAN_FIRST 6'h10
`define TSO_IDX_CHAN_LAST 6'h1f
`define TSO_IDX_ACCFLG 6'h21
`define TSO_IDX_ACC_HI 6'h22
`define TSO_IDX_ACC_LO 6'h23
`define TSO_IDX_PRECISION 6'h24
// =====================================================================
// field positions
`define TSO_BIT_OVF 7
`define TSO_BIT_ACC_OVF 1
`define TSO_BIT_ACC_IN 0
`define TSO_LEGACY_MSB 2
// =====================================================================
// reset values and timing counts
`define TSO_RST_BYTE 8'h00
`define TSO_RST_CTL 5'h00
`define TSO_RST_CNT 16'h0000
`define TSO_DIV64_LAST 6'h3f
`define TSO_CNT_MAX 16'hffff
`endif

// ===== inc/tso_pkg.sv
package tso_pkg;
  typedef struct packed {
    logic wait_mode;
    logic freeze_mode;
    logic test_mode;
  } tso_mode_t;

  typedef struct packed {
    logic timer_enable_bit;
    logic stop_in_wait_bit;
    logic stop_in_freeze_bit;
    logic fast_flag_clear_bit;
    logic precision_select_bit;
  } tso_ctl_t;
endpackage

// ===== test/tso_timer_ctl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tso_timer_ctl_tb import tso_pkg::*;;
  typedef struct packed {
    logic [2:0] src;
    logic [31:0] val;
  } tso_note_t;
  logic clk, rst, psel, pen, pwr, pready, pslverr;
  logic [7:0] pa, cfs, m7, d7, pin, oen, frc, frl;
  logic [31:0] pwd, prdata, rv, npulse;
  tso_mode_t mode;
  logic aos, ais, div, arun, mstop, mark, smp, clr, con, c7c;
  logic [15:0] acnt, cnt;
  logic [2:0] k;
  tso_note_t q[$];
  tso_note_t nt;
  int fails, compares, cyc;
  tso_timer_ctl uut (.clk_i(clk), .reset_i(rst), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .mode_i(mode), .chan_flag_set_i(cfs), .force_i(frc),
    .force_level_i(frl), .oc7_mask_i(m7), .oc7_data_i(d7),
    .ch7_compare_i(c7c), .acc_ovf_set_i(aos), .acc_in_set_i(ais),
    .acc_count_i(acnt), .counter_o(cnt), .oc_pin_o(pin),
    .oc_enable_o(oen), .acc_div64_o(div), .acc_run_o(arun),
    .module_stop_o(mstop));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // =====================================================================
  // checking
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    if (smp || (mark && psel && pen && pready)) begin
      nt = q.pop_front();
      case (nt.src)
        3'h1: check({16'h0, cnt}, nt.val);
        3'h2: check({24'h0, pin}, nt.val);
        3'h3: check({24'h0, oen}, nt.val);
        3'h4: check({31'h0, arun}, nt.val);
        3'h5: check({31'h0, mstop}, nt.val);
        3'h6: check(npulse, nt.val);
        3'h7: begin
          check(prdata, nt.val);
          check({31'h0, pslverr}, 32'h1);
        end
        default: begin
          check(prdata, nt.val);
          check({31'h0, pslverr}, 32'h0);
        end
      endcase
    end
  end
  // window counter of divide-by-64 pulses, exact length in edges
  always @(posedge clk) begin
    npulse <= clr ? 32'h0 : npulse + {31'h0, con & div};
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      test_done();
    end
  end
  // =====================================================================
  // drivers
  task automatic apb(input logic w, input logic [2:0] s,
                     input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] e);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    mark <= !w;
    if (!w) q.push_back('{s, e});
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
    mark <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, 3'h0, a, {24'h0, d}, 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, 3'h0, a, 32'h0, {24'h0, e});
  endtask
  // read of an unmapped word: error response and zero data
  task automatic rdx(input logic [7:0] a);
    apb(1'b0, 3'h7, a, 32'h0, 32'h0);
  endtask
  task automatic note(input logic [2:0] s, input logic [31:0] e);
    q.push_back('{s, e});
    smp <= 1'b1;
    @(posedge clk);
    smp <= 1'b0;
    @(posedge clk);
  endtask
  task automatic window(input logic [31:0] e);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    con <= 1'b1;
    repeat (128) @(posedge clk);
    con <= 1'b0;
    note(3'h6, e);
  endtask
  // =====================================================================
  // sequence
  initial begin
    {rst, psel, pen, pwr, mark, smp, clr, con, aos, ais, c7c} = 11'h400;
    {pa, cfs, m7, d7, frc, frl} = 48'h0;
    pwd = 32'h0;
    mode = 3'b001;
    void'($urandom(6120));
    rv = $urandom;
    acnt = rv[15:0];
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(8'h18, 8'h00);
    rd(8'h1c, 8'h00);
    wr(8'h1c, rv[31:24]);
    rd(8'h1c, rv[31:24]);
    rdx(8'hfc);
    wr(8'h00, 8'h0f);
    note(3'h3, 32'h0f);
    wr(8'h10, 8'hff);
    wr(8'h14, 8'hfe);
    window(32'h0);
    note(3'h1, 32'hfffe);
    wr(8'h1c, 8'h33);
    wr(8'h18, 8'h80);
    window(32'h2);
    wr(8'h18, 8'h00);
    note(3'h2, 32'h03);
    rd(8'h10, 8'h00);
    rd(8'h3c, 8'h80);
    rd(8'h3c, 8'h80);
    // override beats toggle on ch0, toggle beats force on ch1
    wr(8'h00, 8'hff);
    wr(8'h1c, 8'h83);
    m7 <= 8'h01;
    d7 <= 8'h01;
    wr(8'h10, 8'hff);
    wr(8'h14, 8'hfe);
    wr(8'h18, 8'h80);
    // force lands in the overflow cycle, two edges after enable
    @(posedge clk);
    frc <= 8'h07;
    frl <= 8'h07;
    @(posedge clk);
    frc <= 8'h00;
    repeat (18) @(posedge clk);
    wr(8'h18, 8'h00);
    note(3'h2, 32'h85);
    d7 <= 8'h00;
    c7c <= 1'b1;
    @(posedge clk);
    c7c <= 1'b0;
    note(3'h2, 32'h84);
    wr(8'h18, 8'h10);
    wr(8'h14, 8'h00);
    rd(8'h3c, 8'h00);
    // precision bit is locked after the first write
    wr(8'h18, 8'hff);
    rd(8'h18, 8'hf0);
    wr(8'h00, 8'h0f);
    cfs <= 8'h04;
    @(posedge clk);
    cfs <= 8'h10;
    @(posedge clk);
    cfs <= 8'h00;
    rd(8'h38, 8'h14);
    wr(8'h50, 8'h00);
    wr(8'h60, 8'h5a);
    rd(8'h38, 8'h10);
    rd(8'h60, 8'h5a);
    rd(8'h38, 8'h00);
    {aos, ais} <= 2'b11;
    @(posedge clk);
    {aos, ais} <= 2'b00;
    rd(8'h84, 8'h03);
    rd(8'h88, acnt[15:8]);
    rd(8'h84, 8'h00);
    for (int i = 0; i < 8; i++) begin
      k = i[2:0];
      mode <= {k[0], k[1], 1'b1};
      wr(8'h18, {1'b1, k[2], 6'h30});
      note(3'h4, {31'h0, !(k[0] && k[2])});
      note(3'h5, {31'h0, k[0] && k[2]});
    end
    // freeze with stop-in-freeze holds the count
    mode <= 3'b011;
    wr(8'h18, 8'ha0);
    wr(8'h10, 8'h12);
    wr(8'h14, 8'h34);
    repeat (10) @(posedge clk);
    rd(8'h10, 8'h12);
    rd(8'h14, 8'h34);
    wr(8'h10, 8'hff);
    wr(8'h14, 8'hfe);
    wr(8'h3c, 8'h80);
    wr(8'h18, 8'h80);
    repeat (20) @(posedge clk);
    rd(8'h3c, 8'h80);
    // legacy divide by four: ten steps in the enabled span
    wr(8'h18, 8'h00);
    wr(8'h34, 8'h02);
    wr(8'h10, 8'h00);
    wr(8'h14, 8'h00);
    wr(8'h18, 8'h80);
    repeat (40) @(posedge clk);
    wr(8'h18, 8'h00);
    rd(8'h14, 8'h0a);
    // second reset reopens the one-time precision select
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(8'h18, 8'h00);
    wr(8'h90, 8'h03);
    wr(8'h18, 8'h88);
    repeat (40) @(posedge clk);
    wr(8'h18, 8'h00);
    rd(8'h14, 8'h0a);
    rd(8'h18, 8'h08);
    repeat (4) @(posedge clk);
    test_done();
  end
endmodule
`default_nettype wire
